// >>> pkg/uvep_pkg.sv
// Constants and types for the EPROM programming and read controller
// How it works
// - No program pulse during read mode
// - Elevated enable held for whole program sequence
// - Address then data before each pulse
// - Pulse width 0.1 to 1.0 ms
// - Wait one microsecond before next address
// - Each pass starts at address zero
// - Loops times pulse width at least 100 ms
// - Pulse low first, then enable low
// - Release data before changing address on exit
package uvep_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int WORDS = 1024;
  localparam int CLK_NS = 5;
  // Times in their own units
  localparam int PULSE_US = 1000;
  localparam int PULSE_MIN_US = 100;
  localparam int GAP_NS = 1000;
  localparam int SETUP_US = 10;
  localparam int EXIT_US = 10;
  localparam int TOTAL_MS = 100;
  localparam int ACCESS_NS = 450;
  localparam int PULSE_CYC = PULSE_US * 1000 / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = SETUP_US * 1000 / CLK_NS;
  localparam int EXIT_CYC = EXIT_US * 1000 / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOOPS_DEF = TOTAL_MS * 1000 / PULSE_US;
  localparam int CNT_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 10'h000;
  localparam logic [DATA_W-1:0] ERASED = 8'hFF;
  // Three levels of the enable line
  typedef enum logic [1:0] {
    UVEP_EN_LOW = 2'b00,
    UVEP_EN_HIGH = 2'b01,
    UVEP_EN_ELEV = 2'b10
  } uvep_level_e;
  typedef enum logic [3:0] {
    UVEP_IDLE = 4'h0,
    UVEP_RD_WAIT = 4'h1,
    UVEP_PG_ENTER = 4'h2,
    UVEP_PG_ADDR = 4'h3,
    UVEP_PG_DATA = 4'h4,
    UVEP_PG_PULSE = 4'h5,
    UVEP_PG_GAP = 4'h6,
    UVEP_EX_PULSE = 4'h7,
    UVEP_EX_DATA = 4'h8,
    UVEP_EX_SETTLE = 4'h9
  } uvep_state_e;
endpackage

// >>> core/uvep_timer.sv
// Down counter for the controller's timed waits
`timescale 1ns/10ps
module uvep_timer
  import uvep_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // Plain compare; a load term here would loop back through the caller
  assign done = (cnt_q == '0);
endmodule // uvep_timer

// >>> core/uvep_ctrl.sv
// Host controller that reads and programs the EPROM through its pins
`timescale 1ns/10ps
module uvep_ctrl
  import uvep_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int EXIT_CYCLES = EXIT_CYC,
  parameter int LOOPS = LOOPS_DEF,
  parameter int LAST_ADDR = WORDS - 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic pg_start,
  output logic pg_fetch,
  output logic [ADDR_W-1:0] pg_fetch_addr,
  input wire logic [DATA_W-1:0] pg_word,
  output logic busy,
  output logic pg_done,
  output logic [ADDR_W-1:0] word_address,
  output logic [1:0] select_program_enable,
  output logic program_pulse_line,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n
);
  uvep_state_e state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] sel_q;
  logic pulse_q;
  logic [DATA_W-1:0] dout_q;
  logic oe_n_q;
  logic [DATA_W-1:0] sync1_q, sync2_q;
  logic [15:0] loop_q;
  logic rd_valid_q, pg_done_q, fetch_q, busy_q;
  logic [DATA_W-1:0] rd_data_q;
  logic t_load, t_done;
  logic [CNT_W-1:0] t_count;

  ////////////////////////////////////////////////////////////////////
  uvep_timer #(.W(CNT_W)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  // Pin input synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    t_load = 1'b0;
    t_count = '0;
    case (state_q)
      UVEP_IDLE: begin
        if (rd_req) begin
          t_load = 1'b1;
          t_count = CNT_W'(ACCESS_CYC + 2);
        end else if (pg_start) begin
          t_load = 1'b1;
          t_count = CNT_W'(SETUP_CYCLES);
        end
      end
      UVEP_PG_ENTER, UVEP_PG_ADDR: if (t_done) begin
        t_load = 1'b1;
        t_count = CNT_W'(SETUP_CYCLES);
      end
      UVEP_PG_DATA: if (t_done) begin
        t_load = 1'b1;
        // The pulse drops one edge after zero, so load one less
        t_count = CNT_W'(PULSE_CYCLES - 1);
      end
      UVEP_PG_PULSE: if (t_done) begin
        t_load = 1'b1;
        t_count = CNT_W'(GAP_CYC);
      end
      UVEP_PG_GAP: if (t_done) begin
        t_load = 1'b1;
        t_count = CNT_W'(SETUP_CYCLES);
      end
      UVEP_EX_PULSE, UVEP_EX_DATA: if (t_done) begin
        t_load = 1'b1;
        t_count = (state_q == UVEP_EX_DATA) ? CNT_W'(EXIT_CYCLES) : CNT_W'(GAP_CYC);
      end
      default: t_load = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= UVEP_IDLE;
      addr_q <= ADDR_FIRST;
      sel_q <= UVEP_EN_HIGH;
      pulse_q <= 1'b0;
      dout_q <= ERASED;
      oe_n_q <= 1'b1;
      loop_q <= '0;
      fetch_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      fetch_q <= 1'b0;
      case (state_q)
        UVEP_IDLE: begin
          pulse_q <= 1'b0;
          if (rd_req) begin
            addr_q <= rd_addr;
            sel_q <= UVEP_EN_LOW;
            state_q <= UVEP_RD_WAIT;
            busy_q <= 1'b1;
          end else if (pg_start) begin
            sel_q <= UVEP_EN_ELEV;
            state_q <= UVEP_PG_ENTER;
            busy_q <= 1'b1;
          end
        end
        UVEP_RD_WAIT: if (t_done) begin
          sel_q <= UVEP_EN_HIGH;
          state_q <= UVEP_IDLE;
          busy_q <= 1'b0;
        end
        UVEP_PG_ENTER: if (t_done) begin
          addr_q <= ADDR_FIRST;
          loop_q <= '0;
          fetch_q <= 1'b1;
          state_q <= UVEP_PG_ADDR;
        end
        UVEP_PG_ADDR: if (t_done) begin
          dout_q <= pg_word;
          oe_n_q <= 1'b0;
          state_q <= UVEP_PG_DATA;
        end
        UVEP_PG_DATA: if (t_done) begin
          pulse_q <= 1'b1;
          state_q <= UVEP_PG_PULSE;
        end
        UVEP_PG_PULSE: if (t_done) begin
          pulse_q <= 1'b0;
          if (addr_q == ADDR_W'(LAST_ADDR) && loop_q == 16'(LOOPS - 1)) begin
            state_q <= UVEP_EX_PULSE;
          end else begin
            state_q <= UVEP_PG_GAP;
          end
        end
        UVEP_PG_GAP: if (t_done) begin
          if (addr_q == ADDR_W'(LAST_ADDR)) begin
            addr_q <= ADDR_FIRST;
            loop_q <= loop_q + 16'h0001;
          end else begin
            addr_q <= addr_q + ADDR_W'(1);
          end
          fetch_q <= 1'b1;
          state_q <= UVEP_PG_ADDR;
        end
        UVEP_EX_PULSE: if (t_done) begin
          oe_n_q <= 1'b1;
          sel_q <= UVEP_EN_LOW;
          state_q <= UVEP_EX_DATA;
        end
        UVEP_EX_DATA: if (t_done) begin
          state_q <= UVEP_EX_SETTLE;
        end
        UVEP_EX_SETTLE: if (t_done) begin
          sel_q <= UVEP_EN_HIGH;
          state_q <= UVEP_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= UVEP_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read capture after access time and two sync stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= ERASED;
      pg_done_q <= 1'b0;
    end else begin
      rd_valid_q <= (state_q == UVEP_RD_WAIT) && t_done;
      if ((state_q == UVEP_RD_WAIT) && t_done) begin
        rd_data_q <= sync2_q;
      end
      pg_done_q <= (state_q == UVEP_EX_SETTLE) && t_done;
    end
  end

  assign word_address = addr_q;
  assign select_program_enable = sel_q;
  assign program_pulse_line = pulse_q;
  assign data_lines_o = dout_q;
  assign data_lines_oe_n = oe_n_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign pg_fetch = fetch_q;
  assign pg_fetch_addr = addr_q;
  assign pg_done = pg_done_q;
  assign busy = busy_q;
endmodule // uvep_ctrl

// >>> tb/uvep_ctrl_properties.sv
// Pin sequence checker for the EPROM controller
`timescale 1ns/10ps
module uvep_ctrl_properties
  import uvep_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int EXIT_CYCLES = EXIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic busy,
  input wire logic pg_done,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic [1:0] select_program_enable,
  input wire logic program_pulse_line,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic data_lines_oe_n
);
  localparam int SAT = 1 << 20;
  logic [1:0] sel;
  int pw_q, gap_q, ex_q;
  assign sel = select_program_enable;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Gap and exit counters saturate, so a long idle never wraps
  always_ff @(posedge mclk) begin
    pw_q <= (!rst_n || !program_pulse_line) ? 0 : pw_q + 1;
    gap_q <= !rst_n ? SAT : program_pulse_line ? 0 : (gap_q < SAT) ? gap_q + 1 : gap_q;
    ex_q <= !rst_n ? SAT : (sel == 2'b10) ? 0 : (ex_q < SAT) ? ex_q + 1 : ex_q;
  end
  a_no_read_pulse: assert property (program_pulse_line |-> sel == 2'b10)
    else $error("pulse outside program mode");
  a_pulse_width: assert property ($fell(program_pulse_line) |-> pw_q == PULSE_CYCLES)
    else $error("pulse width wrong");
  a_drive_prog_only: assert property (!data_lines_oe_n |-> sel == 2'b10)
    else $error("data driven outside program mode");
  a_setup_held: assert property (program_pulse_line |-> !data_lines_oe_n
    && $stable(data_lines_o) && $stable(word_address)) else $error("setup moved in pulse");
  a_step_gap: assert property (sel == 2'b10 && $changed(word_address) |-> gap_q >= GAP_CYC)
    else $error("address stepped too soon");
  a_exit_order: assert property ($past(sel) == 2'b10 && sel != 2'b10
    |-> !program_pulse_line && gap_q >= GAP_CYC) else $error("left program mode early");
  a_release_first: assert property (sel != 2'b10 && $changed(word_address)
    |-> data_lines_oe_n && $past(data_lines_oe_n)) else $error("address moved under data");
  a_exit_window: assert property (pg_done |-> ex_q >= EXIT_CYCLES)
    else $error("done inside exit window");
  a_read_start: assert property (rd_req && !busy |=> sel == 2'b00
    && word_address == $past(rd_addr) && busy) else $error("read start wrong");
  c_read: cover property (rd_req && !busy);
  c_pulse: cover property ($fell(program_pulse_line));
  c_done: cover property (pg_done);
endmodule // uvep_ctrl_properties

// >>> tb/uvep_eprom_model.sv
// Behavioural model of the erasable PROM at its pins
`timescale 1ns/10ps
module uvep_eprom_model
  import uvep_pkg::*;
(
  input wire logic mclk,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic [1:0] select_program_enable,
  input wire logic program_pulse_line,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic data_lines_oe_n,
  output logic [DATA_W-1:0] q
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] last_q = 8'h00;
  ////////////////////////////////////////
  // erased reads ones
  initial foreach (mem[i]) mem[i] = ERASED;
  // Released lines wander so stale data never passes
  always @(posedge mclk) last_q <= q;
  assign q = (select_program_enable == 2'b00) ? mem[word_address] : ~last_q;
  always @(negedge program_pulse_line)
    if (select_program_enable == 2'b10 && !data_lines_oe_n)
      mem[word_address] = mem[word_address] & data_lines_o;
endmodule // uvep_eprom_model

// >>> tb/uvep_ctrl_tb.sv
// Self-checking bench for the EPROM controller
`timescale 1ns/10ps
module uvep_ctrl_tb;
  import uvep_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, rd_req = 1'b0, pg_start = 1'b0;
  logic [ADDR_W-1:0] rd_addr = 10'h000, word_address, pg_fetch_addr, first_a;
  logic [DATA_W-1:0] rd_data, q, data_lines_o, pg_word, data_lines_i;
  logic [1:0] select_program_enable;
  logic rd_valid, pg_fetch, busy, pg_done, program_pulse_line, data_lines_oe_n;
  int err_count = 0, total_checks = 0, npulse = 0, nfetch = 0;
  always #2.5 mclk = ~mclk;
  assign pg_word = 8'hA5 ^ pg_fetch_addr[7:0];
  assign data_lines_i = data_lines_oe_n ? q : data_lines_o;
  always @(posedge program_pulse_line) begin
    if (npulse == 0) first_a = word_address;
    npulse++;
  end
  // Counted away from the launching edge
  always @(negedge mclk) if (pg_fetch === 1'b1) nfetch++;
  uvep_ctrl #(.PULSE_CYCLES(20), .SETUP_CYCLES(4), .EXIT_CYCLES(4), .LOOPS(2),
    .LAST_ADDR(3)) uut (.mclk(mclk), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .pg_start(pg_start), .pg_fetch(pg_fetch),
    .pg_fetch_addr(pg_fetch_addr), .pg_word(pg_word), .busy(busy), .pg_done(pg_done),
    .word_address(word_address), .select_program_enable(select_program_enable),
    .program_pulse_line(program_pulse_line), .data_lines_i(data_lines_i),
    .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n));
  uvep_eprom_model model (.mclk(mclk), .word_address(word_address),
    .select_program_enable(select_program_enable), .program_pulse_line(program_pulse_line),
    .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n), .q(q));
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string w, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  // Bounded, so a stuck handshake ends the run
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (s !== 1'b1) begin
      err_count++;
      $display("Error handshake expected 1 seen %b", s);
      close_out();
    end
  endtask
  task automatic t_read(logic [9:0] a, logic [7:0] e);
    rd_addr = a;
    rd_req = 1'b1;
    @(posedge mclk);
    #1;
    rd_req = 1'b0;
    pg_start = 1'b1;
    @(posedge mclk);
    #1;
    pg_start = 1'b0;
    wait_hi(rd_valid, 300);
    check("rd_data", e, rd_data);
    $display("read %h done", a);
  endtask
  task automatic t_prog();
    model.mem[1] = 8'h0F;
    pg_start = 1'b1;
    @(posedge mclk);
    #1;
    pg_start = 1'b0;
    wait_hi(pg_done, 9000);
    check("pulses", 8'h08, npulse[7:0]);
    check("fetches", 8'h08, nfetch[7:0]);
    check("first", 8'h00, first_a[7:0]);
    check("word1", 8'h04, model.mem[1]);
    check("word3", 8'hA6, model.mem[3]);
    $display("program done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    model.mem[10'h2A5] = 8'h3C;
    t_read(10'h2A5, 8'h3C);
    t_read(10'h3FF, 8'hFF);
    check("pulses", 8'h00, npulse[7:0]);
    t_prog();
    t_read(10'h001, 8'h04);
    t_read(10'h003, 8'hA6);
    close_out();
  end
endmodule // uvep_ctrl_tb
bind uvep_ctrl uvep_ctrl_properties #(.PULSE_CYCLES(PULSE_CYCLES), .EXIT_CYCLES(EXIT_CYCLES))
  u_chk (.mclk(mclk), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr), .busy(busy),
  .pg_done(pg_done), .word_address(word_address), .select_program_enable(select_program_enable),
  .program_pulse_line(program_pulse_line), .data_lines_o(data_lines_o),
  .data_lines_oe_n(data_lines_oe_n));
